/* File: can_mode_ctrl.sv */
/*
 * CAN operating-mode control with its control and status registers,
 * reached over an AXI4-Lite slave.
 * Assumes a protocol engine on the same clock that supplies a bit tick,
 * transmit activity, receive events and the FIFO and filter status.
 */
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module can_mode_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic busReceivePin,
    output logic busTransmitPin,
    output logic txPinOwned,
    output logic rxPinOwned,
    input wire logic bitTick,
    input wire logic engineTx,
    output logic engineRx,
    output logic engineEnable,
    output logic ackEnable,
    output logic errCountClear,
    output logic errCountEnable,
    output logic ignoreErrors,
    input wire logic txInProgress,
    input wire logic txPending,
    output logic txStartAllowed,
    output logic txAbortOne,
    output logic abortAllTransmit,
    input wire logic allAborted,
    input wire logic rxMessageDone,
    output logic captureEvent,
    input wire logic rxError,
    output logic copyPartialMessage,
    input wire logic chipIdle,
    input wire logic sleepMode,
    output logic wakeActivity,
    output logic mapWindowSelect,
    input wire logic [4:0] netFilterBitCount,
    input wire logic [4:0] matchedFilterNumber,
    input wire logic [6:0] interruptCauseCode,
    input wire logic [5:0] fifoWritePointer,
    input wire logic [5:0] fifoReadPointer,
    output logic [2:0] bufferCountSelect,
    output logic [4:0] fifoStartBuffer
);
    logic [2:0] modeRequest_r;
    logic [2:0] modeInEffect_r;
    logic stopInIdle_r;
    logic abortAll_r;
    logic captureEn_r;
    logic window_r;
    logic [15:0] fifoCtrl_r;
    logic wakeLowpass_r;
    logic rxMeta_r;
    logic rxSync_r;
    logic rxPrev_r;
    logic [3:0] recessiveCnt_r;
    logic [$clog2(can_mode_pkg::WAKE_FILT_CYC + 1)-1:0] dominantCnt_r;
    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] wAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic busIdle;
    logic modeAcceptable;
    logic modeValidReq;
    logic halted;
    logic isConfig;
    logic doWrite;
    logic wrMapped;
    logic [15:0] modeCtrlRead;
    logic [15:0] modeCtrlNew;
    logic [15:0] readWord;
    logic readMapped;
    logic rxLine;
    logic wakeSeen;

    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // The bus pin is asynchronous to clk, so it is synchronised first.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxMeta_r <= 1'b1;
            rxSync_r <= 1'b1;
            rxPrev_r <= 1'b1;
        end else if (clkEn) begin
            rxMeta_r <= busReceivePin;
            rxSync_r <= rxMeta_r;
            rxPrev_r <= rxSync_r;
        end
    end

    assign isConfig = (modeInEffect_r == can_mode_pkg::MODE_CONFIG);
    assign halted = stopInIdle_r && chipIdle;
    assign rxLine = (modeInEffect_r == can_mode_pkg::MODE_LOOPBACK) ? engineTx : rxSync_r;

    // Counting restarts on every mode change so that a freshly entered
    // transmit-capable mode again waits a full idle period.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            recessiveCnt_r <= 4'h0;
        end else if (clkEn) begin
            if (modeInEffect_r != modeRequest_r && modeAcceptable) begin
                recessiveCnt_r <= 4'h0;
            end else if (!rxLine) begin
                recessiveCnt_r <= 4'h0;
            end else if (bitTick && !busIdle) begin
                recessiveCnt_r <= recessiveCnt_r + 4'h1;
            end
        end
    end

    assign busIdle = (recessiveCnt_r >= 4'(can_mode_pkg::IDLE_BITS));
    assign modeValidReq = (modeRequest_r != can_mode_pkg::MODE_RSVD_A)
        && (modeRequest_r != can_mode_pkg::MODE_RSVD_B);

    // From an offline mode the change needs no idle bus.
    always_comb begin
        modeAcceptable = modeValidReq
            && (busIdle || isConfig
                || modeInEffect_r == can_mode_pkg::MODE_DISABLE);
        if (modeRequest_r == can_mode_pkg::MODE_CONFIG && txInProgress) begin
            modeAcceptable = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modeInEffect_r <= can_mode_pkg::MODE_CONFIG;
        end else if (clkEn && modeAcceptable) begin
            modeInEffect_r <= modeRequest_r;
        end
    end

    always_comb begin
        engineEnable = 1'b0;
        ackEnable = 1'b0;
        errCountClear = 1'b0;
        errCountEnable = 1'b0;
        ignoreErrors = 1'b0;
        txPinOwned = 1'b0;
        rxPinOwned = 1'b0;
        unique case (modeInEffect_r)
            can_mode_pkg::MODE_NORMAL: begin
                engineEnable = 1'b1;
                ackEnable = 1'b1;
                errCountEnable = 1'b1;
                txPinOwned = 1'b1;
                rxPinOwned = 1'b1;
            end
            can_mode_pkg::MODE_LOOPBACK: begin
                engineEnable = 1'b1;
                ackEnable = 1'b1;
                errCountEnable = 1'b1;
            end
            can_mode_pkg::MODE_LISTEN_ONLY: begin
                engineEnable = 1'b1;
                rxPinOwned = 1'b1;
            end
            can_mode_pkg::MODE_LISTEN_ALL: begin
                engineEnable = 1'b1;
                ignoreErrors = 1'b1;
                rxPinOwned = 1'b1;
            end
            can_mode_pkg::MODE_CONFIG: begin
                errCountClear = 1'b1;
            end
            default: begin
                engineEnable = 1'b0;
            end
        endcase
        if (halted) begin
            engineEnable = 1'b0;
        end
    end

    assign busTransmitPin = txPinOwned ? engineTx : 1'b1;
    assign engineRx = rxLine;
    assign txStartAllowed = busIdle && engineEnable
        && (modeInEffect_r == can_mode_pkg::MODE_NORMAL
            || modeInEffect_r == can_mode_pkg::MODE_LOOPBACK);
    assign wakeSeen = (dominantCnt_r == ($bits(dominantCnt_r))'(can_mode_pkg::WAKE_FILT_CYC));

    // Dominant level must persist through the filter time before it wakes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dominantCnt_r <= '0;
        end else if (clkEn) begin
            if (rxSync_r || !(wakeLowpass_r && sleepMode)) begin
                dominantCnt_r <= '0;
            end else if (!wakeSeen) begin
                dominantCnt_r <= dominantCnt_r + 1'b1;
            end
        end
    end

    // Event outputs are registered to keep them glitch free; txAbortOne stays high as long as its conditions hold.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeActivity <= 1'b0;
            txAbortOne <= 1'b0;
            captureEvent <= 1'b0;
            copyPartialMessage <= 1'b0;
        end else if (clkEn) begin
            wakeActivity <= (modeInEffect_r == can_mode_pkg::MODE_DISABLE)
                && ((wakeLowpass_r && sleepMode)
                    ? (dominantCnt_r == ($bits(dominantCnt_r))'(can_mode_pkg::WAKE_FILT_CYC - 1))
                    : (rxPrev_r && !rxSync_r));
            txAbortOne <= txPending && !busIdle && !txInProgress
                && modeRequest_r == can_mode_pkg::MODE_DISABLE
                && modeInEffect_r != can_mode_pkg::MODE_DISABLE;
            captureEvent <= captureEn_r && rxMessageDone && engineEnable;
            copyPartialMessage <= rxError && engineEnable
                && modeInEffect_r == can_mode_pkg::MODE_LISTEN_ALL;
        end
    end

    assign awready = !awHeld_r && !bvalid;
    assign wready = !wHeld_r && !bvalid;
    assign doWrite = awHeld_r && wHeld_r && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            wAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= can_mode_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                wAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrMapped ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case ({wAddr_r[7:2], 2'b00})
            can_mode_pkg::OFS_MODE_CTRL, can_mode_pkg::OFS_NET_FILT,
            can_mode_pkg::OFS_INT_CODE, can_mode_pkg::OFS_FIFO_CTRL,
            can_mode_pkg::OFS_FIFO_STAT, can_mode_pkg::OFS_TIMING2: wrMapped = 1'b1;
            default: wrMapped = 1'b0;
        endcase
    end

    assign modeCtrlRead = {2'b00, stopInIdle_r, abortAll_r, 1'b0, modeRequest_r,
                           modeInEffect_r, 1'b0, captureEn_r, 2'b00, window_r};
    assign modeCtrlNew = mergeLanes(modeCtrlRead, wData_r, wStrb_r);

    // The mode control word stays writable in every mode, since otherwise
    // software could never leave an operating mode again.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modeRequest_r <= can_mode_pkg::MODE_CTRL_RESET[can_mode_pkg::REQ_LSB +: 3];
            stopInIdle_r <= can_mode_pkg::MODE_CTRL_RESET[can_mode_pkg::STOP_IDLE_BIT];
            captureEn_r <= can_mode_pkg::MODE_CTRL_RESET[can_mode_pkg::CAP_BIT];
            window_r <= can_mode_pkg::MODE_CTRL_RESET[can_mode_pkg::WIN_BIT];
        end else if (clkEn && doWrite && wAddr_r == can_mode_pkg::OFS_MODE_CTRL) begin
            modeRequest_r <= modeCtrlNew[can_mode_pkg::REQ_LSB +: 3];
            stopInIdle_r <= modeCtrlNew[can_mode_pkg::STOP_IDLE_BIT];
            captureEn_r <= modeCtrlNew[can_mode_pkg::CAP_BIT];
            window_r <= modeCtrlNew[can_mode_pkg::WIN_BIT];
        end
    end

    // A fresh abort request wins over completion in the same cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            abortAll_r <= can_mode_pkg::MODE_CTRL_RESET[can_mode_pkg::ABORT_BIT];
        end else if (clkEn) begin
            if (doWrite && wAddr_r == can_mode_pkg::OFS_MODE_CTRL
                && wStrb_r[1] && wData_r[can_mode_pkg::ABORT_BIT]) begin
                abortAll_r <= 1'b1;
            end else if (allAborted) begin
                abortAll_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fifoCtrl_r <= can_mode_pkg::FIFO_CTRL_RESET;
            wakeLowpass_r <= can_mode_pkg::TIMING2_RESET[can_mode_pkg::WAKE_FILT_BIT];
        end else if (clkEn && doWrite && isConfig) begin
            if (wAddr_r == can_mode_pkg::OFS_FIFO_CTRL) begin
                fifoCtrl_r <= mergeLanes(fifoCtrl_r, wData_r, wStrb_r) & 16'he01f;
            end
            if (wAddr_r == can_mode_pkg::OFS_TIMING2 && wStrb_r[1]) begin
                wakeLowpass_r <= wData_r[can_mode_pkg::WAKE_FILT_BIT];
            end
        end
    end

    assign abortAllTransmit = abortAll_r;
    assign mapWindowSelect = window_r;
    assign bufferCountSelect = fifoCtrl_r[can_mode_pkg::BUFCNT_LSB +: 3];
    assign fifoStartBuffer = fifoCtrl_r[4:0];

    always_comb begin
        readMapped = 1'b1;
        unique case ({araddr[7:2], 2'b00})
            can_mode_pkg::OFS_MODE_CTRL: readWord = modeCtrlRead;
            can_mode_pkg::OFS_NET_FILT: readWord = {11'h000, netFilterBitCount};
            can_mode_pkg::OFS_INT_CODE: readWord = {3'h0, matchedFilterNumber, 1'b0,
                                                    interruptCauseCode};
            can_mode_pkg::OFS_FIFO_CTRL: readWord = fifoCtrl_r;
            can_mode_pkg::OFS_FIFO_STAT: readWord = {2'b00, fifoWritePointer, 2'b00,
                                                     fifoReadPointer};
            can_mode_pkg::OFS_TIMING2: readWord = {1'b0, wakeLowpass_r, 14'h0000};
            default: begin
                readWord = 16'h0000;
                readMapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= can_mode_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= {16'h0000, readWord};
                rresp <= readMapped ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: can_mode_pkg.sv */
/*
 * Constants for the CAN mode and FIFO control block: register offsets,
 * field positions, mode codes, reset values and timing counts.
 * Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package can_mode_pkg;
    localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFS_NET_FILT = 8'h04;
    localparam logic [7:0] OFS_INT_CODE = 8'h08;
    localparam logic [7:0] OFS_FIFO_CTRL = 8'h0c;
    localparam logic [7:0] OFS_FIFO_STAT = 8'h10;
    localparam logic [7:0] OFS_TIMING2 = 8'h14;

    localparam int REQ_LSB = 8;
    localparam int MODE_LSB = 5;
    localparam int STOP_IDLE_BIT = 13;
    localparam int ABORT_BIT = 12;
    localparam int CAP_BIT = 3;
    localparam int WIN_BIT = 0;
    localparam int HIT_LSB = 8;
    localparam int BUFCNT_LSB = 13;
    localparam int WPTR_LSB = 8;
    localparam int WAKE_FILT_BIT = 14;

    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_DISABLE = 3'h1;
    localparam logic [2:0] MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] MODE_LISTEN_ONLY = 3'h3;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam logic [2:0] MODE_RSVD_A = 3'h5;
    localparam logic [2:0] MODE_RSVD_B = 3'h6;
    localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;

    localparam logic [15:0] MODE_CTRL_RESET = 16'h0480;
    localparam logic [15:0] FIFO_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TIMING2_RESET = 16'h0000;
    localparam logic [4:0] NET_FILT_MAX = 5'h11;
    localparam logic [4:0] HIT_MAX = 5'h0f;
    localparam logic [2:0] BUFCNT_RSVD = 3'h7;

    localparam int IDLE_BITS = 11;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_FILT_NS = 1000;
    localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: can_mode_checker.sv */
/*
 Port checker for can_mode_ctrl.
 Assumes one clock, clkEn mostly high, bound to every instance.
*/
`timescale 1ns/100ps
`default_nettype none
module can_mode_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic awvalid,
    input wire logic wvalid,
    input wire logic busTransmitPin,
    input wire logic txPinOwned,
    input wire logic rxPinOwned,
    input wire logic engineTx,
    input wire logic engineRx,
    input wire logic engineEnable,
    input wire logic ackEnable,
    input wire logic errCountClear,
    input wire logic errCountEnable,
    input wire logic ignoreErrors,
    input wire logic txInProgress,
    input wire logic txPending,
    input wire logic txStartAllowed,
    input wire logic txAbortOne,
    input wire logic abortAllTransmit,
    input wire logic allAborted,
    input wire logic rxMessageDone,
    input wire logic captureEvent,
    input wire logic rxError,
    input wire logic copyPartialMessage,
    input wire logic wakeActivity
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    pin_release_a: assert property (!txPinOwned |-> busTransmitPin)
        else $error("transmit pin not recessive when released");
    pin_pair_a: assert property (txPinOwned |-> rxPinOwned)
        else $error("transmit pin owned without receive pin");
    loop_route_a: assert property (engineEnable && !rxPinOwned |-> engineRx == engineTx)
        else $error("loopback receive differs from transmit");
    config_quiet_a: assert property (errCountClear |-> !engineEnable && !txStartAllowed)
        else $error("engine active while counters cleared");
    listen_quiet_a: assert property (rxPinOwned && !txPinOwned && engineEnable && !ignoreErrors
        |-> !ackEnable && !errCountEnable)
        else $error("acknowledge or counters on while listening");
    abort_clear_a: assert property (abortAllTransmit && allAborted && clkEn && !wvalid &&
        !awvalid && !$past(wvalid) && !$past(awvalid) |=> !abortAllTransmit)
        else $error("abort-all not cleared");
    capture_cause_a: assert property (captureEvent && $past(clkEn) |-> $past(rxMessageDone))
        else $error("capture event without received message");
    partial_copy_a: assert property (copyPartialMessage && $past(clkEn)
        |-> $past(rxError && ignoreErrors))
        else $error("partial copy without error in listen-all");
    abort_one_a: assert property (txAbortOne && $past(clkEn)
        |-> $past(txPending && !txInProgress))
        else $error("single abort without pending request");
    wake_off_a: assert property (wakeActivity |-> !engineEnable && !txPinOwned)
        else $error("wake activity outside disable");
endmodule
bind can_mode_ctrl can_mode_checker can_mode_checker_inst (.clk, .arst_n, .clkEn, .awvalid,
    .wvalid, .busTransmitPin, .txPinOwned, .rxPinOwned, .engineTx, .engineRx, .engineEnable,
    .ackEnable, .errCountClear, .errCountEnable, .ignoreErrors, .txInProgress, .txPending,
    .txStartAllowed, .txAbortOne, .abortAllTransmit, .allAborted, .rxMessageDone,
    .captureEvent, .rxError, .copyPartialMessage, .wakeActivity);
`default_nettype wire

/* File: can_bus_node.sv */
/*
 Far-side bus model: makes the bit tick and the receive level.
 Assumes the bench's clock; busy makes traffic that never idles.
*/
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic busy,
    output logic bitTick,
    output logic busReceivePin
);
    logic [1:0] div_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    assign bitTick = (div_r == 2'h3);
    // A wired-and bus idles recessive; busy toggles each bit so no idle run forms.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busReceivePin <= 1'b1;
        end else if (!busy) begin
            busReceivePin <= 1'b1;
        end else if (bitTick) begin
            busReceivePin <= !busReceivePin;
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
/*
 Self-checking bench for can_mode_ctrl over AXI4-Lite.
 Assumes the design, its package, the checker and the bus node model.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, arst_n, clkEn, awvalid, wvalid, bready, arvalid, rready, busy;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, busReceivePin, busTransmitPin;
    logic txPinOwned, rxPinOwned, bitTick, engineTx, engineRx, engineEnable, ackEnable;
    logic errCountClear, errCountEnable, ignoreErrors, txInProgress, txPending;
    logic txStartAllowed, txAbortOne, abortAllTransmit, allAborted, rxMessageDone;
    logic captureEvent, rxError, copyPartialMessage, chipIdle, sleepMode, wakeActivity;
    logic mapWindowSelect;
    logic [4:0] netFilterBitCount, matchedFilterNumber, fifoStartBuffer;
    logic [6:0] interruptCauseCode;
    logic [5:0] fifoWritePointer, fifoReadPointer;
    logic [2:0] bufferCountSelect;
    int miscompares, comparisons, i, n;
    logic [7:0] rowAddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [15:0] rowData [7] = '{16'h0480, 16'h0011, 16'h0f44, 16'hc01f, 16'h1f00,
        16'h4000, 16'h0000};
    logic [2:0] modes [3] = '{3'h3, 3'h7, 3'h2};
    can_mode_ctrl can_mode_ctrl_inst (.clk, .arst_n, .clkEn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .busReceivePin, .busTransmitPin,
        .txPinOwned, .rxPinOwned, .bitTick, .engineTx, .engineRx, .engineEnable, .ackEnable,
        .errCountClear, .errCountEnable, .ignoreErrors, .txInProgress, .txPending,
        .txStartAllowed, .txAbortOne, .abortAllTransmit, .allAborted, .rxMessageDone,
        .captureEvent, .rxError, .copyPartialMessage, .chipIdle, .sleepMode, .wakeActivity,
        .mapWindowSelect, .netFilterBitCount, .matchedFilterNumber, .interruptCauseCode,
        .fifoWritePointer, .fifoReadPointer, .bufferCountSelect, .fifoStartBuffer);
    can_bus_node can_bus_node_inst (.clk, .arst_n, .busy, .bitTick, .busReceivePin);
    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tmo;
        miscompares++;
        $display("BAD wait expected answer seen none");
        results();
    endtask
    task wr(input logic [7:0] a, input logic [15:0] v);
        awaddr <= a;
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) tmo();
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) tmo();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task waitMode(input logic [2:0] m);
        for (i = 0; i < 80; i++) begin
            rd(8'h00);
            if (d[7:5] === m) break;
        end
        chk("mode", 32'(d[7:5]), 32'(m));
        if (i == 80) tmo();
    endtask
    // A static task cannot take a ref argument, so the strobe is picked by number.
    task pulse(input int which);
        @(posedge clk);
        rxMessageDone <= (which == 0);
        allAborted <= (which == 1);
        rxError <= (which == 2);
        @(posedge clk);
        {rxMessageDone, allAborted, rxError} <= 3'h0;
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, busy} = '0;
        engineTx = 1'b1;
        {txInProgress, txPending, allAborted, rxMessageDone, rxError, chipIdle} = '0;
        {sleepMode, awaddr, araddr, wdata} = '0;
        clkEn = 1'b1;
        wstrb = 4'hf;
        netFilterBitCount = 5'h11;
        matchedFilterNumber = 5'h0f;
        interruptCauseCode = 7'h44;
        fifoWritePointer = 6'h1f;
        fifoReadPointer = 6'h00;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        wr(8'h0c, 16'hc01f);
        wr(8'h14, 16'h4000);
        for (int k = 0; k < 7; k++) begin
            rd(rowAddr[k]);
            chk("reg", d, {16'h0000, rowData[k]});
            chk("resp", 32'(r), (k == 6) ? 32'h2 : 32'h0);
        end
        chk("bufcnt", 32'(bufferCountSelect), 32'h6);
        chk("fifostart", 32'(fifoStartBuffer), 32'h1f);
        $display("done register table");
        wr(8'h00, 16'h0009);
        waitMode(3'h0);
        chk("pins", {txPinOwned, rxPinOwned, mapWindowSelect}, 32'h7);
        wr(8'h0c, 16'h0000);
        rd(8'h0c);
        chk("locked", d, 32'hc01f);
        pulse(0);
        chk("capture", 32'(captureEvent), 32'h1);
        wr(8'h00, 16'h2009);
        chipIdle <= 1'b1;
        @(posedge clk);
        #1 chk("idlestop", 32'(engineEnable), 32'h0);
        chipIdle <= 1'b0;
        wr(8'h00, 16'h1009);
        chk("abortset", 32'(abortAllTransmit), 32'h1);
        pulse(1);
        chk("abortclr", 32'(abortAllTransmit), 32'h0);
        for (int k = 5; k < 7; k++) begin
            wr(8'h00, {5'h00, 3'(k), 8'h09});
            repeat (60) @(posedge clk);
            rd(8'h00);
            chk("rsvd", 32'(d[7:5]), 32'h0);
        end
        chk("txok", 32'(txStartAllowed), 32'h1);
        $display("done normal mode");
        busy <= 1'b1;
        txPending <= 1'b1;
        // The idle count must be broken before the disable request lands.
        repeat (8) @(posedge clk);
        wr(8'h00, 16'h0109);
        i = 0;
        repeat (60) begin
            @(posedge clk);
            if (txAbortOne === 1'b1) i++;
        end
        chk("abortone", 32'(i > 0), 32'h1);
        rd(8'h00);
        chk("held", 32'(d[7:5]), 32'h0);
        chk("txstart", 32'(txStartAllowed), 32'h0);
        busy <= 1'b0;
        txPending <= 1'b0;
        waitMode(3'h1);
        chk("released", {txPinOwned, rxPinOwned}, 32'h0);
        busy <= 1'b1;
        i = 0;
        repeat (20) begin
            @(posedge clk);
            if (wakeActivity === 1'b1) i++;
        end
        chk("wake", 32'(i > 0), 32'h1);
        busy <= 1'b0;
        txInProgress <= 1'b1;
        wr(8'h00, 16'h0409);
        repeat (60) @(posedge clk);
        rd(8'h00);
        chk("refused", 32'(d[7:5]), 32'h1);
        txInProgress <= 1'b0;
        waitMode(3'h4);
        chk("clear", 32'(errCountClear), 32'h1);
        $display("done disable");
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, {5'h00, modes[k], 8'h09});
            waitMode(modes[k]);
            engineTx <= 1'b0;
            @(posedge clk);
            #1;
            if (k == 0) chk("listen", {txPinOwned, rxPinOwned, ackEnable, errCountEnable,
                busTransmitPin}, 32'h9);
            if (k == 2) chk("loop", {txPinOwned, rxPinOwned, engineRx}, 32'h0);
            if (k == 1) begin
                chk("ignore", 32'(ignoreErrors), 32'h1);
                pulse(2);
                chk("copy", 32'(copyPartialMessage), 32'h1);
            end
            // In loopback the idle count follows the engine's own transmit level.
            engineTx <= 1'b1;
            wr(8'h00, 16'h0409);
            waitMode(3'h4);
        end
        $display("done mode list");
        results();
    end
endmodule
`default_nettype wire
